// >>> hw/hmsi_regs.vh
// register offsets, field positions and timing counts for the host/micro bridge
`ifndef HMSI_REGS_VH
`define HMSI_REGS_VH
// =============================================
// micro side register indices (byte address = 4 * index)
`define HMSI_R_INSTAT 4'h0
`define HMSI_R_LCS0 4'h1
`define HMSI_R_LCS1 4'h2
`define HMSI_R_LCS2 4'h3
`define HMSI_R_RXLO 4'h4
`define HMSI_R_RXHI 4'h5
`define HMSI_R_TXEN 4'h6
`define HMSI_R_CARRIER 4'h7
`define HMSI_R_RING 4'h8
`define HMSI_R_SWLED 4'h9
// =============================================
// input status bits
`define HMSI_IS_LCSAVAIL 0
`define HMSI_IS_RXFULL 1
`define HMSI_IS_LCSALARM 2
`define HMSI_IS_RXALARM 3
`define HMSI_IS_MAINT 4
// =============================================
// host word offsets (address bits 2:1)
`define HMSI_H_CSR 2'h0
`define HMSI_H_RECEIVE_BUFFER_REG 2'h1
`define HMSI_H_TCR 2'h2
`define HMSI_H_MSR 2'h3
// =============================================
// control and status bits
`define HMSI_CSR_MAINT 3
`define HMSI_CSR_CLR 4
`define HMSI_CSR_MSE 5
`define HMSI_CSR_RIE 6
`define HMSI_CSR_RECEIVE_DONE_BIT 7
`define HMSI_CSR_SAE 12
`define HMSI_CSR_SA 13
`define HMSI_CSR_TIE 14
`define HMSI_CSR_TRANSMITTER_READY 15
// =============================================
// line control silo entry tags (bits 23:16)
`define HMSI_TAG_LPR 8'h01
`define HMSI_TAG_DTR 8'h02
`define HMSI_TAG_TDR 8'h03
// =============================================
// timing
`define HMSI_CLK_MHZ 20
`define HMSI_SSYN_NS 150
`define HMSI_SSYN_CYC ((`HMSI_SSYN_NS * `HMSI_CLK_MHZ + 999) / 1000)
`define HMSI_SCAN_DIV 16
`define HMSI_ALARM_LEVEL 16
`define HMSI_VECTOR 9'h0c0
`define HMSI_VEC_STEP 9'h004
`endif

// >>> hw/hmsi_fifo.v
// first in first out store with separate load and unload ports
`timescale 1ns/1ps
`default_nettype none
module hmsi_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 64,
   parameter AW = 6
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // load side
   input wire push,
   input wire [WIDTH-1:0] pushData,
   output wire full,
   // unload side
   input wire pop,
   output wire [WIDTH-1:0] popData,
   output wire empty,
   // occupancy
   output wire [AW:0] count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_q;
   reg [AW:0] rdPtr_q;
   wire doPush;
   wire doPop;

   // =============================================
   // pointers
   assign count = wrPtr_q - rdPtr_q;
   assign full = (count == DEPTH[AW:0]);
   assign empty = (count == {(AW+1){1'b0}});
   assign doPush = push & ~full;
   assign doPop = pop & ~empty;
   assign popData = mem[rdPtr_q[AW-1:0]];

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         wrPtr_q <= {(AW+1){1'b0}};
         rdPtr_q <= {(AW+1){1'b0}};
      end else begin
         if (doPush)
            wrPtr_q <= wrPtr_q + 1'b1;
         if (doPop)
            rdPtr_q <= rdPtr_q + 1'b1;
      end
   end

   always @(posedge clk_sys) begin
      if (doPush)
         mem[wrPtr_q[AW-1:0]] <= pushData;
   end
endmodule // hmsi_fifo
`default_nettype wire

// >>> hw/hmsi_top.v
// host bus to microcontroller bridge with silos and interrupts
`timescale 1ns/1ps
`default_nettype none
`include "hmsi_regs.vh"
module hmsi_top #(
   parameter SCAN_DIV = `HMSI_SCAN_DIV,
   parameter [8:0] VECTOR = `HMSI_VECTOR
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // microcontroller avalon slave
   input wire [3:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [31:0] avsWritedata,
   input wire [3:0] avsByteenable,
   output reg [31:0] avsReaddata,
   output wire avsWaitrequest,
   // host bus slave
   input wire [12:1] hostAddr,
   input wire hostMsyn,
   input wire hostWrite,
   input wire [15:0] hostWdata,
   output reg [15:0] hostRdata,
   output reg hostSsyn,
   // host interrupt
   output wire hostBr5,
   input wire hostBg5,
   output reg hostSack,
   output reg hostBbsy,
   output reg hostIntr,
   output reg [15:0] hostVector,
   // board switches and indicators
   input wire [9:0] addrSwitch,
   input wire [7:0] maintSwitch,
   output reg [7:0] ledOut
);
   localparam IDLE = 2'h0;
   localparam SACK = 2'h1;
   localparam VECT = 2'h2;
   localparam integer SSYN_CYC_I = `HMSI_SSYN_CYC;
   localparam [2:0] SSYN_CYC = SSYN_CYC_I[2:0];

   // =============================================
   // state
   reg avAck_q;
   reg [7:0] rxLo_q;
   reg [7:0] microTxEn_q;
   reg [7:0] carrier_q;
   reg [7:0] ring_q;
   reg [15:0] csr_q;
   reg [7:0] hostTxEn_q;
   reg [7:0] dtr_q;
   reg [2:0] dly_q;
   reg msynDly_q;
   reg rbufCycle_q;
   reg [3:0] alarmCnt_q;
   reg rxAlarm_q;
   reg [2:0] line_q;
   reg [7:0] scanDiv_q;
   reg transmitter_ready_q;
   reg rxCond_q;
   reg rxPend_q;
   reg txPend_q;
   reg [1:0] irqSt_q;
   reg servRx_q;
   wire avTake;
   wire avWr;
   wire [15:0] rxOut;
   wire rxEmpty;
   wire rxFull;
   wire [6:0] rxCount;
   wire [23:0] lcsOut;
   wire lcsEmpty;
   wire lcsFull;
   wire [6:0] lcsCount;
   wire lcsAlarm;
   wire match;
   wire hostTake;
   wire hostEnd;
   wire [1:0] hReg;
   wire rxPush;
   wire lcsPop;
   reg lcsPush;
   reg [23:0] lcsIn;
   wire rxCond;
   wire txOk;
   wire trdyRise;

   function [15:0] setBit;
      input [15:0] val;
      input [3:0] pos;
      input bitv;
      begin
         setBit = val;
         setBit[pos] = bitv;
      end
   endfunction

   // =============================================
   // microcontroller avalon slave, one wait cycle
   assign avTake = (avsRead | avsWrite) & avAck_q;
   assign avsWaitrequest = (avsRead | avsWrite) & ~avAck_q;
   assign avWr = avTake & avsWrite & avsByteenable[0];
   assign rxPush = avWr & (avsAddress == `HMSI_R_RXHI);
   assign lcsPop = avTake & avsRead & (avsAddress == `HMSI_R_LCS2);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         avAck_q <= 1'b0;
         avsReaddata <= 32'h0;
      end else begin
         avAck_q <= (avsRead | avsWrite) & ~avAck_q;
         if ((avsRead & ~avAck_q)) begin
            avsReaddata <= 32'h0;
            case (avsAddress)
               `HMSI_R_INSTAT: begin
                  avsReaddata[`HMSI_IS_LCSAVAIL] <= ~lcsEmpty;
                  avsReaddata[`HMSI_IS_RXFULL] <= rxFull;
                  avsReaddata[`HMSI_IS_LCSALARM] <= lcsAlarm;
                  avsReaddata[`HMSI_IS_RXALARM] <= rxAlarm_q;
                  avsReaddata[`HMSI_IS_MAINT] <= csr_q[`HMSI_CSR_MAINT];
               end
               `HMSI_R_LCS0: avsReaddata[7:0] <= lcsOut[7:0];
               `HMSI_R_LCS1: avsReaddata[7:0] <= lcsOut[15:8];
               `HMSI_R_LCS2: avsReaddata[7:0] <= lcsOut[23:16];
               `HMSI_R_TXEN: avsReaddata[7:0] <= microTxEn_q;
               `HMSI_R_SWLED: avsReaddata[7:0] <= maintSwitch;
               default: avsReaddata <= 32'h0;
            endcase
         end
      end
   end

   // micro writable bytes; host maintenance copy shares carrier/ring
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rxLo_q <= 8'h0;
         microTxEn_q <= 8'h0;
         carrier_q <= 8'h0;
         ring_q <= 8'h0;
         ledOut <= 8'h0;
      end else begin
         if (avWr) begin
            case (avsAddress)
               `HMSI_R_RXLO: rxLo_q <= avsWritedata[7:0];
               `HMSI_R_TXEN: microTxEn_q <= avsWritedata[7:0];
               `HMSI_R_CARRIER: carrier_q <= avsWritedata[7:0];
               `HMSI_R_RING: ring_q <= avsWritedata[7:0];
               `HMSI_R_SWLED: ledOut <= avsWritedata[7:0];
               default: rxLo_q <= rxLo_q;
            endcase
         end
         if (hostTake & hostWrite & (hReg == `HMSI_H_TCR) &
             csr_q[`HMSI_CSR_MAINT]) begin
            carrier_q <= hostWdata[15:8];
            ring_q <= hostWdata[15:8];
         end
      end
   end

   // =============================================
   // silos
   hmsi_fifo #(.WIDTH(16), .DEPTH(64), .AW(6)) rxSilo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .push(rxPush),
      .pushData({avsWritedata[7:0], rxLo_q}),
      .full(rxFull),
      .pop(hostEnd & rbufCycle_q),
      .popData(rxOut),
      .empty(rxEmpty),
      .count(rxCount)
   );

   hmsi_fifo #(.WIDTH(24), .DEPTH(64), .AW(6)) lcsSilo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .push(lcsPush),
      .pushData(lcsIn),
      .full(lcsFull),
      .pop(lcsPop),
      .popData(lcsOut),
      .empty(lcsEmpty),
      .count(lcsCount)
   );

   assign lcsAlarm = (lcsCount >= `HMSI_ALARM_LEVEL);

   // =============================================
   // host address decode and slave sync
   assign match = (hostAddr[12:3] == addrSwitch);
   assign hReg = hostAddr[2:1];
   assign hostTake = hostMsyn & match & ~hostSsyn & (dly_q == SSYN_CYC);
   assign hostEnd = msynDly_q & ~hostMsyn;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         dly_q <= 3'h0;
         hostSsyn <= 1'b0;
         msynDly_q <= 1'b0;
         rbufCycle_q <= 1'b0;
         hostRdata <= 16'h0;
      end else begin
         msynDly_q <= hostMsyn;
         if (!hostMsyn) begin
            dly_q <= 3'h0;
            hostSsyn <= 1'b0;
         end else if (match & ~hostSsyn) begin
            if (dly_q != SSYN_CYC)
               dly_q <= dly_q + 3'h1;
            else
               hostSsyn <= 1'b1;
         end
         if (hostEnd)
            rbufCycle_q <= 1'b0;
         if (hostTake & ~hostWrite) begin
            rbufCycle_q <= (hReg == `HMSI_H_RECEIVE_BUFFER_REG) & ~rxEmpty;
            case (hReg)
               `HMSI_H_CSR: hostRdata <= {transmitter_ready_q, csr_q[14], rxAlarm_q,
                  csr_q[12], 1'b0, line_q, ~rxEmpty, csr_q[6:3], 3'h0};
               `HMSI_H_RECEIVE_BUFFER_REG: hostRdata <= rxEmpty ? 16'h0 :
                  {rxOut[15:12], 1'b0, rxOut[10:0]};
               `HMSI_H_TCR: hostRdata <= {dtr_q, hostTxEn_q};
               `HMSI_H_MSR: hostRdata <= {carrier_q, ring_q};
               default: hostRdata <= 16'h0;
            endcase
         end
      end
   end

   // host register writes and silo loading
   always @* begin
      lcsPush = 1'b0;
      lcsIn = {`HMSI_TAG_LPR, hostWdata};
      if (hostTake & hostWrite) begin
         case (hReg)
            `HMSI_H_RECEIVE_BUFFER_REG: lcsPush = 1'b1;
            `HMSI_H_TCR: begin
               lcsPush = 1'b1;
               lcsIn = {`HMSI_TAG_DTR, 8'h0, hostWdata[15:8]};
            end
            `HMSI_H_MSR: begin
               lcsPush = 1'b1;
               lcsIn = {`HMSI_TAG_TDR, hostWdata};
            end
            default: lcsPush = 1'b0;
         endcase
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         csr_q <= 16'h0;
         hostTxEn_q <= 8'h0;
         dtr_q <= 8'h0;
      end else if (hostTake & hostWrite) begin
         if (hReg == `HMSI_H_CSR) begin
            csr_q <= 16'h0;
            csr_q[6:3] <= hostWdata[6:3];
            csr_q[12] <= hostWdata[12];
            csr_q[14] <= hostWdata[14];
         end
         if (hReg == `HMSI_H_TCR) begin
            hostTxEn_q <= hostWdata[7:0];
            dtr_q <= hostWdata[15:8];
         end
      end
   end

   // =============================================
   // receive alarm counter
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         alarmCnt_q <= 4'h0;
         rxAlarm_q <= 1'b0;
      end else if (hostTake & ~hostWrite & (hReg == `HMSI_H_RECEIVE_BUFFER_REG)) begin
         alarmCnt_q <= {3'h0, rxPush & ~rxFull};
         rxAlarm_q <= 1'b0;
      end else if (rxPush & ~rxFull) begin
         alarmCnt_q <= alarmCnt_q + 4'h1;
         if (alarmCnt_q == 4'hf)
            rxAlarm_q <= 1'b1;
      end
   end

   // =============================================
   // transmit scanner
   assign txOk = microTxEn_q[line_q] & hostTxEn_q[line_q] &
                 csr_q[`HMSI_CSR_MSE] & ~lcsAlarm;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         line_q <= 3'h0;
         scanDiv_q <= 8'h0;
         transmitter_ready_q <= 1'b0;
      end else if (transmitter_ready_q) begin
         if ((hostTake & hostWrite & (hReg == `HMSI_H_MSR)) |
             ~hostTxEn_q[line_q] | ~csr_q[`HMSI_CSR_MSE])
            transmitter_ready_q <= 1'b0;
      end else if (scanDiv_q == SCAN_DIV[7:0] - 8'h1) begin
         scanDiv_q <= 8'h0;
         if (txOk)
            transmitter_ready_q <= 1'b1;
         else
            line_q <= line_q + 3'h1;
      end else begin
         scanDiv_q <= scanDiv_q + 8'h1;
      end
   end

   // =============================================
   // interrupt requests and vector dialogue
   assign rxCond = (~rxEmpty & csr_q[`HMSI_CSR_RIE]) |
                   (rxAlarm_q & csr_q[`HMSI_CSR_SAE]);
   assign trdyRise = ~transmitter_ready_q & (scanDiv_q == SCAN_DIV[7:0] - 8'h1) & txOk;
   assign hostBr5 = (rxPend_q | txPend_q) & (irqSt_q == IDLE);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rxCond_q <= 1'b0;
         rxPend_q <= 1'b0;
         txPend_q <= 1'b0;
         irqSt_q <= IDLE;
         servRx_q <= 1'b0;
         hostSack <= 1'b0;
         hostBbsy <= 1'b0;
         hostIntr <= 1'b0;
         hostVector <= 16'h0;
      end else begin
         rxCond_q <= rxCond;
         case (irqSt_q)
            IDLE: begin
               if (hostBg5 & (rxPend_q | txPend_q)) begin
                  hostSack <= 1'b1;
                  hostBbsy <= 1'b1;
                  servRx_q <= rxPend_q;
                  irqSt_q <= SACK;
               end
            end
            SACK: begin
               hostIntr <= 1'b1;
               hostVector <= servRx_q ? {7'h0, VECTOR} :
                  {7'h0, VECTOR + `HMSI_VEC_STEP};
               irqSt_q <= VECT;
            end
            VECT: begin
               if (!hostBg5) begin
                  hostSack <= 1'b0;
                  hostBbsy <= 1'b0;
                  hostIntr <= 1'b0;
                  hostVector <= 16'h0;
                  irqSt_q <= IDLE;
               end
            end
            default: irqSt_q <= IDLE;
         endcase
         if (irqSt_q == SACK) begin
            if (servRx_q)
               rxPend_q <= 1'b0;
            else
               txPend_q <= 1'b0;
         end
         if (rxCond & ~rxCond_q)
            rxPend_q <= 1'b1;
         if (trdyRise & csr_q[`HMSI_CSR_TIE])
            txPend_q <= 1'b1;
      end
   end
endmodule // hmsi_top
`default_nettype wire

// >>> bench/hmsi_host_model.sv
// host bus master model: word cycles and interrupt grants
`timescale 1ns/1ps
`default_nettype none
module hmsi_host_model (
   // clock
   input wire logic clk_sys,
   // host bus master
   output logic [12:1] hostAddr,
   output logic hostMsyn,
   output logic hostWrite,
   output logic [15:0] hostWdata,
   input wire logic [15:0] hostRdata,
   input wire logic hostSsyn,
   // interrupt grant
   input wire logic hostBr5,
   output logic hostBg5,
   input wire logic hostIntr,
   input wire logic [15:0] hostVector
);
   initial begin
      hostAddr = 12'h0;
      hostMsyn = 1'b0;
      hostWrite = 1'b0;
      hostWdata = 16'h0;
      hostBg5 = 1'b0;
   end
   // ========
   // one word cycle, held until slave sync
   task automatic xfer(input logic wr, input logic [12:1] a,
      input logic [15:0] d, output logic [15:0] q, output logic ok);
      int n;
      n = 0;
      hostAddr <= a;
      hostWrite <= wr;
      hostWdata <= d;
      hostMsyn <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hostSsyn !== 1'b1 && n < 20);
      ok = hostSsyn;
      q = hostRdata;
      hostMsyn <= 1'b0;
      hostWdata <= ~d;
      repeat (2) @(posedge clk_sys);
   endtask
   // ========
   // grant once a request stands, held until interrupt
   task automatic grant(output logic [15:0] v);
      int n;
      n = 0;
      while (hostBr5 !== 1'b1 && n < 600) begin
         @(posedge clk_sys);
         n++;
      end
      hostBg5 <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hostIntr !== 1'b1 && n < 20);
      v = hostVector;
      hostBg5 <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule // hmsi_host_model
`default_nettype wire

// >>> bench/hmsi_top_chk.sv
// port assertions for the host/micro bridge
`timescale 1ns/1ps
`default_nettype none
module hmsi_top_chk #(
   parameter SCAN_DIV = 16,
   parameter [8:0] VECTOR = 9'h0c0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // micro bus
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsReaddata,
   input wire logic avsWaitrequest,
   // host bus
   input wire logic [12:1] hostAddr,
   input wire logic hostMsyn,
   input wire logic hostSsyn,
   input wire logic [9:0] addrSwitch,
   input wire logic hostBr5,
   input wire logic hostBg5,
   input wire logic hostSack,
   input wire logic hostBbsy,
   input wire logic hostIntr,
   input wire logic [15:0] hostVector
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire hostMatch = (hostAddr[12:3] == addrSwitch);
   // ========
   a_wait_once: assert property (
      (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
      else $error("waitrequest held too long");
   a_byte_wide: assert property (
      avsRead && !avsWaitrequest |-> avsReaddata[31:8] == 24'h0)
      else $error("read data above low byte");
   a_no_match: assert property (
      hostMsyn && !hostMatch && !hostSsyn |=> !hostSsyn)
      else $error("slave sync without address match");
   a_ssyn_wait: assert property (
      $rose(hostMsyn) && hostMatch |-> !hostSsyn [*3] ##[1:3] hostSsyn)
      else $error("slave sync timing wrong");
   a_ssyn_hold: assert property (
      hostSsyn && hostMsyn |=> hostSsyn)
      else $error("slave sync dropped early");
   a_ssyn_drop: assert property (
      hostSsyn && !hostMsyn |=> !hostSsyn)
      else $error("slave sync held too long");
   a_sack_cause: assert property (
      $rose(hostSack) |-> $past(hostBg5) && $past(hostBr5))
      else $error("acknowledge without grant");
   a_ack_busy: assert property (
      $rose(hostSack) |-> hostBbsy && !hostIntr ##1 hostBbsy && hostIntr)
      else $error("busy and interrupt late");
   a_grant_drop: assert property (
      !hostBg5 && hostSack |=> !hostSack && !hostIntr)
      else $error("acknowledge held after grant");
   a_vector_pair: assert property (
      hostIntr |-> hostVector == {7'h0, VECTOR} ||
         hostVector == {7'h0, VECTOR} + 16'h0004)
      else $error("bad vector");
endmodule // hmsi_top_chk
bind hmsi_top hmsi_top_chk #(.SCAN_DIV(SCAN_DIV), .VECTOR(VECTOR)) chk_u (
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .avsRead(avsRead),
   .avsWrite(avsWrite),
   .avsReaddata(avsReaddata),
   .avsWaitrequest(avsWaitrequest),
   .hostAddr(hostAddr),
   .hostMsyn(hostMsyn),
   .hostSsyn(hostSsyn),
   .addrSwitch(addrSwitch),
   .hostBr5(hostBr5),
   .hostBg5(hostBg5),
   .hostSack(hostSack),
   .hostBbsy(hostBbsy),
   .hostIntr(hostIntr),
   .hostVector(hostVector)
);
`default_nettype wire

// >>> bench/test_hmsi_top.sv
// self-checking bench for the host/micro bridge
`timescale 1ns/1ps
`default_nettype none
`include "hmsi_regs.vh"
module test_hmsi_top;
   localparam logic [9:0] SW = 10'h2a5;
   localparam logic [15:0] VEC = {7'h0, `HMSI_VECTOR};
   // ========
   // design signals
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avsAddress = 4'h0;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0;
   logic [3:0] avsByteenable = 4'h1;
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   wire [12:1] hostAddr;
   wire hostMsyn, hostWrite, hostBg5;
   wire [15:0] hostWdata;
   logic [15:0] hostRdata, hostVector;
   logic hostSsyn, hostBr5, hostSack, hostBbsy, hostIntr;
   logic [9:0] addrSwitch = SW;
   logic [7:0] maintSwitch = 8'h9c;
   logic [7:0] ledOut;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;
   hmsi_top #(.SCAN_DIV(2)) dut_u (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .avsAddress(avsAddress),
      .avsRead(avsRead),
      .avsWrite(avsWrite),
      .avsWritedata(avsWritedata),
      .avsByteenable(avsByteenable),
      .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest),
      .hostAddr(hostAddr),
      .hostMsyn(hostMsyn),
      .hostWrite(hostWrite),
      .hostWdata(hostWdata),
      .hostRdata(hostRdata),
      .hostSsyn(hostSsyn),
      .hostBr5(hostBr5),
      .hostBg5(hostBg5),
      .hostSack(hostSack),
      .hostBbsy(hostBbsy),
      .hostIntr(hostIntr),
      .hostVector(hostVector),
      .addrSwitch(addrSwitch),
      .maintSwitch(maintSwitch),
      .ledOut(ledOut)
   );
   hmsi_host_model host_u (
      .clk_sys(clk_sys),
      .hostAddr(hostAddr),
      .hostMsyn(hostMsyn),
      .hostWrite(hostWrite),
      .hostWdata(hostWdata),
      .hostRdata(hostRdata),
      .hostSsyn(hostSsyn),
      .hostBr5(hostBr5),
      .hostBg5(hostBg5),
      .hostIntr(hostIntr),
      .hostVector(hostVector)
   );
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         $display("BAD %0t timeout", $time);
         err_count++;
         report_and_stop();
      end
   end
   // ========
   // helpers
   task automatic report_and_stop();
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic avs(input logic wr, input logic [3:0] i,
      input logic [7:0] d, output logic [7:0] q);
      avsAddress <= i;
      avsWritedata <= {24'h0, d};
      avsWrite <= wr;
      avsRead <= !wr;
      do begin
         @(posedge clk_sys);
      end while (avsWaitrequest !== 1'b0);
      q = avsReaddata[7:0];
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic mwr(input logic [3:0] i, input logic [7:0] d);
      logic [7:0] q;
      avs(1'b1, i, d, q);
   endtask
   task automatic mrd(input logic [3:0] i, input logic [7:0] exp);
      logic [7:0] q;
      avs(1'b0, i, 8'h0, q);
      chk({24'h0, q}, {24'h0, exp});
   endtask
   task automatic mlcs(input logic [23:0] exp, input logic [23:0] m);
      logic [7:0] q0, q1, q2;
      avs(1'b0, `HMSI_R_LCS0, 8'h0, q0);
      avs(1'b0, `HMSI_R_LCS1, 8'h0, q1);
      avs(1'b0, `HMSI_R_LCS2, 8'h0, q2);
      chk({8'h0, {q2, q1, q0} & m}, {8'h0, exp});
   endtask
   task automatic hwr(input logic [1:0] r, input logic [15:0] d);
      logic [15:0] q;
      logic ok;
      host_u.xfer(1'b1, {SW, r}, d, q, ok);
      chk({31'h0, ok}, 32'h1);
   endtask
   task automatic hchk(input logic [1:0] r, input logic [15:0] m,
      input logic [15:0] exp);
      logic [15:0] q;
      logic ok;
      host_u.xfer(1'b0, {SW, r}, 16'h0, q, ok);
      chk({31'h0, ok}, 32'h1);
      chk({16'h0, q & m}, {16'h0, exp});
   endtask
   // ========
   // scenarios
   task automatic t_idle();
      logic [15:0] q;
      logic ok;
      mrd(`HMSI_R_INSTAT, 8'h00);
      mrd(4'hc, 8'h00);
      hchk(`HMSI_H_MSR, 16'hffff, 16'h0000);
      mrd(`HMSI_R_SWLED, 8'h9c);
      mwr(`HMSI_R_SWLED, 8'h3c);
      chk({24'h0, ledOut}, 32'h3c);
      host_u.xfer(1'b0, {~SW, 2'h0}, 16'h0, q, ok);
      chk({31'h0, ok}, 32'h0);
   endtask
   task automatic t_modem();
      mwr(`HMSI_R_CARRIER, 8'h5a);
      mwr(`HMSI_R_RING, 8'ha5);
      hchk(`HMSI_H_MSR, 16'hffff, 16'h5aa5);
      hwr(`HMSI_H_CSR, 16'h0008);
      mrd(`HMSI_R_INSTAT, 8'h10);
      hwr(`HMSI_H_TCR, 16'hc300);
      hchk(`HMSI_H_MSR, 16'hffff, 16'hc3c3);
      mrd(`HMSI_R_INSTAT, 8'h11);
      mlcs({`HMSI_TAG_DTR, 16'h00c3}, 24'hffffff);
      hwr(`HMSI_H_CSR, 16'h0000);
      hwr(`HMSI_H_RECEIVE_BUFFER_REG, 16'h1234);
      hwr(`HMSI_H_MSR, 16'h0041);
      mlcs({`HMSI_TAG_LPR, 16'h1234}, 24'hffffff);
      mlcs({`HMSI_TAG_TDR, 16'h0041}, 24'hffffff);
   endtask
   task automatic t_rx();
      logic [15:0] v;
      mwr(`HMSI_R_RXLO, 8'h41);
      mwr(`HMSI_R_RXHI, 8'hf3);
      mwr(`HMSI_R_RXLO, 8'h42);
      mwr(`HMSI_R_RXHI, 8'h05);
      hchk(`HMSI_H_CSR, 16'h0080, 16'h0080);
      hchk(`HMSI_H_RECEIVE_BUFFER_REG, 16'hffff, 16'hf341);
      hchk(`HMSI_H_RECEIVE_BUFFER_REG, 16'hffff, 16'h0542);
      hchk(`HMSI_H_CSR, 16'h0080, 16'h0000);
      for (int k = 0; k < 16; k++) begin
         mwr(`HMSI_R_RXLO, k[7:0]);
         mwr(`HMSI_R_RXHI, 8'h02);
         if (k == 14) begin
            mrd(`HMSI_R_INSTAT, 8'h00);
         end
      end
      mrd(`HMSI_R_INSTAT, 8'h08);
      hchk(`HMSI_H_CSR, 16'h2000, 16'h2000);
      hwr(`HMSI_H_CSR, 16'h1000);
      host_u.grant(v);
      chk({16'h0, v}, {16'h0, VEC});
      for (int k = 0; k < 16; k++) begin
         hchk(`HMSI_H_RECEIVE_BUFFER_REG, 16'hffff, {8'h02, k[7:0]});
      end
   endtask
   task automatic t_irq();
      logic [15:0] v;
      hwr(`HMSI_H_CSR, 16'h0040);
      mwr(`HMSI_R_RXLO, 8'h55);
      mwr(`HMSI_R_RXHI, 8'h01);
      host_u.grant(v);
      chk({16'h0, v}, {16'h0, VEC});
      hchk(`HMSI_H_RECEIVE_BUFFER_REG, 16'hffff, 16'h0155);
      hwr(`HMSI_H_CSR, 16'h4020);
      hwr(`HMSI_H_TCR, 16'h0004);
      mlcs({`HMSI_TAG_DTR, 16'h0}, 24'hff0000);
      repeat (200) @(posedge clk_sys);
      hchk(`HMSI_H_CSR, 16'h8000, 16'h0000);
      mwr(`HMSI_R_TXEN, 8'h04);
      host_u.grant(v);
      chk({16'h0, v}, {16'h0, VEC + 16'h0004});
      hchk(`HMSI_H_CSR, 16'h8700, 16'h8200);
      mwr(`HMSI_R_TXEN, 8'h00);
      hwr(`HMSI_H_MSR, 16'h0043);
      mlcs({`HMSI_TAG_TDR, 16'h0043}, 24'hff00ff);
      hchk(`HMSI_H_CSR, 16'h8000, 16'h0000);
      hwr(`HMSI_H_CSR, 16'h0000);
   endtask
   // ========
   // main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_idle();
      t_modem();
      t_rx();
      t_irq();
      report_and_stop();
   end
endmodule // test_hmsi_top
`default_nettype wire
